// ==== logic/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam longint CLK_FREQ_HZ      = 64'd125000000;
    localparam int     POR_TIME_MS      = 10;
    localparam longint POR_CYCLES_CALC  = (CLK_FREQ_HZ * POR_TIME_MS) / 64'd1000;
    localparam int     TMR_W            = 21;
    localparam logic [TMR_W-1:0] CONVERT_STROBE_CYCLES      = 21'd1624;
    localparam logic [TMR_W-1:0] CONVERT_STROBE_CONT_CYCLES = 21'd1622;
    localparam logic [TMR_W-1:0] CAL_CYCLES       = 21'd3246;
    localparam logic [TMR_W-1:0] WAKE_CYCLES      = 21'd1800;
    // ****************************************
    // synchroniser lanes
    // ****************************************
    localparam int SYNC_N       = 6;
    localparam int SYN_STROBE   = 0;
    localparam int SYN_CAL      = 1;
    localparam int SYN_POL      = 2;
    localparam int SYN_SLEEP    = 3;
    localparam int SYN_OSC      = 4;
    localparam int SYN_EXTCLK   = 5;
    localparam logic [SYNC_N-1:0] SYNC_RESET = 6'h00;
    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [6:0] {
        ST_POR   = 7'h01,
        ST_OSC   = 7'h02,
        ST_WAKE  = 7'h04,
        ST_IDLE  = 7'h08,
        ST_CONVERT_STROBE  = 7'h10,
        ST_CAL   = 7'h20,
        ST_SLEEP = 7'h40
    } seq_state_t;
    localparam seq_state_t STATE_RESET = ST_POR;
endpackage
`default_nettype wire

// ==== logic/timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
    import adc_seq_pkg::*;
    logic             load;
    logic [TMR_W-1:0] load_value;
    logic             done;
    modport ctrl (output load, output load_value, input done);
    modport tmr  (input load, input load_value, output done);
endinterface
`default_nettype wire

// ==== logic/cycle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    timer_if.tmr      tif
);
    import adc_seq_pkg::*;

    logic [TMR_W-1:0] count_reg;

    // done fires n cycles after a load of n
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (tif.load) begin
            count_reg <= tif.load_value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 21'd1;
        end
    end

    // done reads the count alone, so a reload decided from done forms no loop
    assign tif.done = (count_reg == 21'd1);
endmodule // cycle_timer
`default_nettype wire

// ==== logic/adc_conversion_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - normal conversion takes 1624 clock cycles
// - back-to-back conversion under held strobe: 1622
// - calibration takes 3246 clock cycles
// - start within three clock cycles of strobe
// - power-on reset on reset and sleep exit
// - 1800 cycle wake-up after oscillator or reset
// - sleep level powers down, full restart after
module adc_conversion_sequencer #(
    parameter int unsigned POR_CYCLES = 32'(adc_seq_pkg::POR_CYCLES_CALC)
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // controller pins
    input  wire logic convert_strobe,
    input  wire logic cal_select,
    input  wire logic polarity_select,
    input  wire logic port_mode_sleep_pin,
    input  wire logic channel_sel_0,
    input  wire logic channel_sel_1,
    // clock source status
    input  wire logic osc_running,
    input  wire logic ext_clock_sel,
    // status
    output logic      result_ready_n,
    output logic      convert_strobe_busy,
    output logic      cal_busy,
    output logic      bipolar_result,
    output logic [1:0] result_channel,
    output adc_seq_pkg::seq_state_t seq_state
);
    import adc_seq_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [SYNC_N-1:0] pin_raw;
    logic [SYNC_N-1:0] sync1_reg;
    logic [SYNC_N-1:0] sync2_reg;
    logic [SYNC_N-1:0] prev_reg;
    logic [1:0]        chan_raw;
    logic [1:0]        chan1_reg;
    logic [1:0]        chan2_reg;

    assign pin_raw = {ext_clock_sel, osc_running, port_mode_sleep_pin,
                      polarity_select, cal_select, convert_strobe};
    assign chan_raw = {channel_sel_1, channel_sel_0};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    prev_reg[gi]  <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    prev_reg[gi]  <= sync2_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chan1_reg <= 2'h0;
            chan2_reg <= 2'h0;
        end else begin
            chan1_reg <= chan_raw;
            chan2_reg <= chan1_reg;
        end
    end

    logic strobe_s;
    logic cal_s;
    logic strobe_rise;
    logic cal_rise;
    assign strobe_s    = sync2_reg[SYN_STROBE];
    assign cal_s       = sync2_reg[SYN_CAL];
    assign strobe_rise = strobe_s && !prev_reg[SYN_STROBE];
    assign cal_rise    = cal_s && !prev_reg[SYN_CAL];

    // ****************************************
    // timers
    // ****************************************
    timer_if tif ();

    cycle_timer u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .tif   (tif)
    );

    // power-on reset is long, kept on its own counter
    logic [TMR_W-1:0] por_count_reg;
    logic             por_done;
    assign por_done = (por_count_reg == TMR_W'(POR_CYCLES));

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_t state_reg;
    seq_state_t state_next;
    logic       start_convert_strobe;
    logic       start_cal;
    logic       cont_convert_strobe;
    logic       op_done;
    logic       sleep_s;

    // states in which a timed operation is running
    function automatic logic op_state(input seq_state_t st);
        return (st == ST_CONVERT_STROBE) || (st == ST_CAL);
    endfunction

    assign sleep_s    = sync2_reg[SYN_SLEEP];
    assign start_cal  = (strobe_rise && cal_s) || (cal_rise && strobe_s);
    assign start_convert_strobe = strobe_rise && !cal_s;
    assign cont_convert_strobe  = (state_reg == ST_CONVERT_STROBE) && tif.done && strobe_s && !cal_s;
    assign op_done    = tif.done && op_state(state_reg);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_count_reg <= '0;
        end else if (state_reg != ST_POR) begin
            por_count_reg <= '0;
        end else if (!por_done) begin
            por_count_reg <= por_count_reg + 21'd1;
        end
    end

    always_comb begin
        state_next     = state_reg;
        tif.load       = 1'b0;
        tif.load_value = CONVERT_STROBE_CYCLES;
        case (state_reg)
            ST_POR: begin
                if (por_done && sync2_reg[SYN_EXTCLK]) begin
                    state_next     = ST_WAKE;
                    tif.load       = 1'b1;
                    tif.load_value = WAKE_CYCLES;
                end else if (por_done) begin
                    state_next = ST_OSC;
                end
            end
            ST_OSC: begin
                if (sync2_reg[SYN_OSC]) begin
                    state_next     = ST_WAKE;
                    tif.load       = 1'b1;
                    tif.load_value = WAKE_CYCLES;
                end
            end
            ST_WAKE: begin
                if (tif.done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (start_cal) begin
                    state_next     = ST_CAL;
                    tif.load       = 1'b1;
                    tif.load_value = CAL_CYCLES;
                end else if (start_convert_strobe) begin
                    state_next     = ST_CONVERT_STROBE;
                    tif.load       = 1'b1;
                    tif.load_value = CONVERT_STROBE_CYCLES;
                end
            end
            ST_CONVERT_STROBE: begin
                if (cont_convert_strobe) begin
                    tif.load       = 1'b1;
                    tif.load_value = CONVERT_STROBE_CONT_CYCLES;
                end else if (tif.done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_CAL: begin
                if (tif.done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SLEEP: begin
                if (!sleep_s) begin
                    state_next = ST_POR;
                end
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
        if (sleep_s && (state_reg != ST_SLEEP)) begin
            state_next = ST_SLEEP;
            tif.load   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // status outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_ready_n <= 1'b1;
        end else if (sleep_s) begin
            result_ready_n <= 1'b1;
        end else if (op_done) begin
            result_ready_n <= 1'b0;
        end else if (op_state(state_reg) || tif.load) begin
            result_ready_n <= 1'b1;
        end
    end

    // polarity sampled when the result completes; its setup lies with the controller
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bipolar_result <= 1'b0;
        end else if (op_done && (state_reg == ST_CONVERT_STROBE)) begin
            bipolar_result <= sync2_reg[SYN_POL];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_channel <= 2'h0;
        end else if (tif.load && (state_next == ST_CONVERT_STROBE)) begin
            result_channel <= chan2_reg;
        end
    end

    assign convert_strobe_busy = (state_reg == ST_CONVERT_STROBE);
    assign cal_busy  = (state_reg == ST_CAL);
    assign seq_state = state_reg;
endmodule // adc_conversion_sequencer
`default_nettype wire

// ==== bench/host_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***
// controller pins
// ***
module host_ctrl_model (
    input  wire logic clk,
    output logic      convert_strobe,
    output logic      cal_select,
    output logic      polarity_select,
    output logic      channel_sel_0,
    output logic      channel_sel_1
);
    initial begin
        convert_strobe  = 1'b0;
        cal_select      = 1'b0;
        polarity_select = 1'b0;
        channel_sel_0   = 1'b0;
        channel_sel_1   = 1'b0;
    end
    // selects settle a cycle ahead of the strobe and stay put afterwards
    task automatic pulse(input logic cal, input logic pol, input logic [1:0] ch, input int hold);
        @(posedge clk);
        cal_select <= cal;
        polarity_select <= pol;
        {channel_sel_1, channel_sel_0} <= ch;
        @(posedge clk);
        convert_strobe <= 1'b1;
        repeat (hold) @(posedge clk); // 13 cycles exceeds 100 ns
        convert_strobe <= 1'b0;
    endtask
    // calibration by raising the select alone while the strobe is already high
    task automatic select_pulse;
        @(posedge clk);
        cal_select <= 1'b0;
        repeat (4) @(posedge clk);
        cal_select <= 1'b1;
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// ==== bench/seq_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***
// sequencer checker
// ***
module seq_checker
    import adc_seq_pkg::*;
#(parameter int unsigned POR_CYCLES = 20) (
    input wire logic       clk, rst_n, convert_strobe, port_mode_sleep_pin,
    input wire logic       result_ready_n, convert_strobe_busy, cal_busy,
    input wire seq_state_t seq_state
);
    seq_state_t  prev_reg;
    logic        prdy_reg;
    logic        reload_reg;
    logic [20:0] cnt_reg;
    wire convert_strobe_end = prev_reg == ST_CONVERT_STROBE && prdy_reg && !result_ready_n;
    always_ff @(posedge clk) begin
        prev_reg <= rst_n ? seq_state : ST_POR;
        prdy_reg <= result_ready_n;
    end
    // cycles spent in the current operation
    always_ff @(posedge clk) begin
        if (!rst_n || seq_state != prev_reg || (convert_strobe_busy && !result_ready_n)) cnt_reg <= 21'h1;
        else cnt_reg <= cnt_reg + 21'h1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) reload_reg <= 1'b0;
        else if (convert_strobe_end) reload_reg <= seq_state == ST_CONVERT_STROBE;
        else if (seq_state == ST_CONVERT_STROBE && prev_reg != ST_CONVERT_STROBE) reload_reg <= 1'b0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_start;
        $rose(convert_strobe) && seq_state == ST_IDLE && !port_mode_sleep_pin;
    endsequence
    sequence s_busy;
        convert_strobe_busy || cal_busy;
    endsequence
    chk_start_latency: assert property (s_start |-> ##[1:3] s_busy)
        else $error("operation did not start after strobe");
    chk_convert_strobe_length: assert property (convert_strobe_end |-> cnt_reg == (reload_reg ? 21'd1622 : 21'd1624))
        else $error("conversion length wrong");
    chk_cal_length: assert property (prev_reg == ST_CAL && seq_state == ST_IDLE |-> cnt_reg == 21'd3246)
        else $error("calibration length wrong");
    chk_wake_length: assert property (prev_reg == ST_WAKE && seq_state == ST_IDLE |-> cnt_reg == 21'd1800)
        else $error("wake-up length wrong");
    chk_por_length: assert property (prev_reg == ST_POR && !(seq_state inside {ST_POR, ST_SLEEP})
        |-> cnt_reg >= POR_CYCLES - 1 && cnt_reg <= POR_CYCLES + 2)
        else $error("power-on reset length wrong");
    chk_ready_high_busy: assert property ($rose(convert_strobe_busy) || $rose(cal_busy) |-> result_ready_n)
        else $error("ready low at operation start");
    chk_ready_hold: assert property (seq_state == ST_IDLE && !result_ready_n |=> s_busy or
        (!result_ready_n || seq_state == ST_SLEEP)) else $error("ready released without a start");
    chk_sleep_enter: assert property (port_mode_sleep_pin [*3] |-> ##[1:2] seq_state == ST_SLEEP)
        else $error("sleep not entered");
    chk_sleep_quiet: assert property (seq_state == ST_SLEEP |-> result_ready_n && !(convert_strobe_busy || cal_busy))
        else $error("activity during sleep");
    chk_sleep_exit: assert property (seq_state == ST_SLEEP && !port_mode_sleep_pin |-> ##[1:3] seq_state == ST_POR)
        else $error("sleep exit without power-on reset");
endmodule // seq_checker
bind adc_conversion_sequencer seq_checker #(.POR_CYCLES(POR_CYCLES)) i_seq_checker (.clk(clk), .rst_n(rst_n),
    .convert_strobe(convert_strobe), .port_mode_sleep_pin(port_mode_sleep_pin), .result_ready_n(result_ready_n),
    .convert_strobe_busy(convert_strobe_busy), .cal_busy(cal_busy), .seq_state(seq_state));
`default_nettype wire

// ==== bench/tb_adc_conversion_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
    import adc_seq_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, port_mode_sleep_pin = 1'b0, osc_running = 1'b0, ext_clock_sel = 1'b1;
    wire  convert_strobe, cal_select, polarity_select, channel_sel_0, channel_sel_1;
    wire  result_ready_n, convert_strobe_busy, cal_busy, bipolar_result;
    wire  [1:0] result_channel;
    seq_state_t seq_state;
    int mismatches = 0, samples_checked = 0;
    initial forever #4 clk = ~clk;
    host_ctrl_model i_host_ctrl_model (.clk, .convert_strobe, .cal_select, .polarity_select,
        .channel_sel_0, .channel_sel_1);
    adc_conversion_sequencer #(.POR_CYCLES(20)) i_adc_conversion_sequencer (.clk, .rst_n, .convert_strobe,
        .cal_select, .polarity_select, .port_mode_sleep_pin, .channel_sel_0, .channel_sel_1, .osc_running,
        .ext_clock_sel, .result_ready_n, .convert_strobe_busy, .cal_busy, .bipolar_result, .result_channel, .seq_state);
    // ***
    // helpers
    // ***
    task check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task wait_state(input seq_state_t st);
        for (int i = 0; i < 5000 && seq_state !== st; i++) tick();
        if (seq_state !== st) begin
            mismatches++;
            end_of_test();
        end
    endtask
    // cycles until ready falls
    task count_ready(output int n);
        n = 0;
        do begin
            tick();
            n++;
        end while (result_ready_n !== 1'b0 && n < 5000);
        if (n >= 5000) begin
            mismatches++;
            end_of_test();
        end
    endtask
    // ***
    // scenarios
    // ***
    task single_convert_strobe;
        int n;
        fork i_host_ctrl_model.pulse(1'b0, 1'b1, 2'h2, 13); join_none
        wait_state(ST_CONVERT_STROBE);
        count_ready(n);
        check("conversion cycles", 21'(n), 21'd1624);
        check("polarity", bipolar_result, 21'h1);
        check("channel", result_channel, 21'h2);
    endtask
    task continuous_convert_strobe;
        int n;
        fork i_host_ctrl_model.pulse(1'b0, 1'b0, 2'h1, 4000); join_none
        wait_state(ST_CONVERT_STROBE);
        count_ready(n);
        check("first of run", 21'(n), 21'd1624);
        count_ready(n);
        check("reload cycles", 21'(n), 21'd1622);
        count_ready(n);
        check("last reload", 21'(n), 21'd1622);
        check("polarity low", bipolar_result, 21'h0);
        check("channel of run", result_channel, 21'h1);
        tick();
        check("idle after run", seq_state, ST_IDLE);
    endtask
    task calibration;
        int n;
        fork i_host_ctrl_model.pulse(1'b1, 1'b1, 2'h3, 3300); join_none
        wait_state(ST_CAL);
        count_ready(n);
        check("calibration cycles", 21'(n), 21'd3246);
        check("channel kept", result_channel, 21'h2);
        // strobe still high: a rise of the select alone starts another
        i_host_ctrl_model.select_pulse();
        wait_state(ST_CAL);
        count_ready(n);
        check("select calibration", 21'(n), 21'd3246);
    endtask
    task sleep_restart;
        fork i_host_ctrl_model.pulse(1'b0, 1'b1, 2'h0, 13); join_none
        wait_state(ST_CONVERT_STROBE);
        repeat (100) tick();
        @(posedge clk) port_mode_sleep_pin <= 1'b1;
        wait_state(ST_SLEEP);
        check("ready in sleep", result_ready_n, 21'h1);
        @(posedge clk) {port_mode_sleep_pin, ext_clock_sel} <= 2'h0;
        wait_state(ST_OSC);
        repeat (50) tick();
        check("waits for oscillator", seq_state, ST_OSC);
        @(posedge clk) osc_running <= 1'b1;
        wait_state(ST_IDLE);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tick();
        check("ready after reset", result_ready_n, 21'h1);
        wait_state(ST_IDLE);
        single_convert_strobe();
        calibration();
        continuous_convert_strobe();
        sleep_restart();
        single_convert_strobe();
        end_of_test();
    end
endmodule // tb_adc_conversion_sequencer
`default_nettype wire
